/* rtl/sfp_params.svh */
// Overview of operation
// - Receive mirroring copies every packet from a receive-monitored port to the monitor port.
// - Transmit mirroring copies every packet sent on a transmit-monitored port to monitor.
// - Combined mode mirrors packets from receive-monitored ports to transmit-monitored ports.
// - An option also sends received errored packets to the monitor port.
// - Several ports may be monitored; any port may be the monitor port.
// - Rate steps: 64Kbps up to 960Kbps, then 1Mbps steps up to link speed.
// - Each port has independent receive and transmit rate limits.
// - On a 10 megabit link, settings above 10Mbps mean unlimited.
// - Frame size counts DA through FCS, optionally plus inter-frame gap or preamble.
// - Ingress limiting counts only selected frame types: all, multicast, broadcast, flooded unicast.
// - Ingress packets are dropped while the measured rate exceeds the limit.
// - Egress leaky bucket stretches the gap between frames per frame.
// - Unknown unicast destinations are dropped or flooded per configuration.
// - Far-end loopback routes one PHY port through the other and back.
// - Near-end loopback turns traffic around at the same PHY port.
// - Destination lookups search static and learned tables; source lookups only learned.
// - A destination match in both tables uses the static result.
// - Static entries never age; only the external processor changes them.
// - Entry used only when valid bit set; optional filter group match.
// - Override bit forwards despite disabled transmit or receive on the port.
// - Forward bits pick ports one per bit; all ones floods except ingress.
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH
`define SFP_TBL_DEPTH   8
`define SFP_TBL_AW      3
`define SFP_ENT_W       58
`define SFP_FID_HI      57
`define SFP_FID_LO      54
`define SFP_USE_FID     53
`define SFP_OVERRIDE    52
`define SFP_VALID       51
`define SFP_FWD_HI      50
`define SFP_FWD_LO      48
`define SFP_MAC_HI      47
`define SFP_FWD_BCAST   3'h7
`define SFP_RATE_W      7
`define SFP_KSTEP_MAX   7'h0F
`define SFP_10M_CODE    7'h19
`define SFP_KSTEP_BYTES 16'h0008
`define SFP_MSTEP_BYTES 16'h007D
`define SFP_IFG_BYTES   16'h000C
`define SFP_PRE_BYTES   16'h0008
`define SFP_BKT_CAP     16'h2000
`define SFP_TICK_NS     1000000
`define SFP_CLK_NS      40
`endif

/* rtl/sfp_pkg.sv */
package sfp_pkg;
   typedef enum logic [1:0] {sfp_mir_off, sfp_mir_rx, sfp_mir_tx, sfp_mir_both} sfp_mir_e;
   typedef enum logic [1:0] {sfp_ing_all, sfp_ing_mc, sfp_ing_bc, sfp_ing_flood} sfp_ing_e;
   typedef enum logic [1:0] {sfp_st_idle, sfp_st_read, sfp_st_check, sfp_st_decide} sfp_state_e;
endpackage

/* rtl/sfp_static_mem.sv */
`timescale 1ns/1ps
`include "sfp_params.svh"
module sfp_static_mem (
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   input  wire logic                        wr_en,
   input  wire logic [`SFP_TBL_AW-1:0]      wr_addr,
   input  wire logic [`SFP_ENT_W-1:0]       wr_data,
   input  wire logic [`SFP_TBL_AW-1:0]      a_addr,
   output logic      [`SFP_ENT_W-1:0]       a_data,
   input  wire logic [`SFP_TBL_AW-1:0]      b_addr,
   output logic      [`SFP_ENT_W-1:0]       b_data
);
   logic [`SFP_ENT_W-1:0] mem_reg [0:`SFP_TBL_DEPTH-1];

   // Entries clear to invalid; nothing but the write port alters them
   // processor-only changes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `SFP_TBL_DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   // Registered read ports: lookup side and processor side
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         a_data <= '0;
         b_data <= '0;
      end else begin
         a_data <= mem_reg[a_addr];
         b_data <= mem_reg[b_addr];
      end
   end
endmodule

/* rtl/sfp_forwarding_policy.sv */
`timescale 1ns/1ps
`include "sfp_params.svh"
module sfp_forwarding_policy
   import sfp_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `SFP_TICK_NS / `SFP_CLK_NS
) (
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   input  wire logic                        tbl_wr,
   input  wire logic                        tbl_rd,
   input  wire logic [`SFP_TBL_AW-1:0]      tbl_addr,
   input  wire logic [`SFP_ENT_W-1:0]       tbl_wdata,
   output logic      [`SFP_ENT_W-1:0]       tbl_rdata,
   output logic                             tbl_rvalid,
   input  wire sfp_mir_e                    cfg_mir_mode,
   input  wire logic [2:0]                  cfg_rx_sniff,
   input  wire logic [2:0]                  cfg_tx_sniff,
   input  wire logic [1:0]                  cfg_sniff_port,
   input  wire logic                        cfg_sniff_bad,
   input  wire logic                        cfg_unk_uc_fwd,
   input  wire logic [2:0]                  cfg_tx_en,
   input  wire logic [2:0]                  cfg_rx_en,
   input  wire sfp_ing_e                    cfg_ing_type,
   input  wire logic                        cfg_add_ifg,
   input  wire logic                        cfg_add_pre,
   input  wire logic [3*`SFP_RATE_W-1:0]    cfg_ing_rate,
   input  wire logic [3*`SFP_RATE_W-1:0]    cfg_egr_rate,
   input  wire logic [2:0]                  link_10m,
   input  wire logic                        cfg_far_loop,
   input  wire logic [1:0]                  cfg_near_loop,
   input  wire logic                        pkt_valid,
   output logic                             pkt_ready,
   input  wire logic [1:0]                  pkt_src,
   input  wire logic [47:0]                 pkt_da,
   input  wire logic [3:0]                  pkt_filter_group_id,
   input  wire logic [10:0]                 pkt_len,
   input  wire logic                        pkt_err,
   input  wire logic                        pkt_mcast,
   input  wire logic                        pkt_bcast,
   input  wire logic                        dyn_hit,
   input  wire logic [2:0]                  dyn_ports,
   output logic                             fwd_valid,
   output logic [2:0]                       fwd_ports,
   output logic                             fwd_drop,
   input  wire logic [2:0]                  egr_req,
   input  wire logic [32:0]                 egr_len,
   output logic [2:0]                       egr_grant,
   output logic                             phy_far_loop,
   output logic [1:0]                       phy_near_loop
);
   sfp_state_e               state_reg;
   logic [`SFP_TBL_AW-1:0]   idx_reg;
   logic [1:0]               src_reg;
   logic [47:0]              da_reg;
   logic [3:0]               fid_reg;
   logic [15:0]              len_reg;
   logic                     err_reg;
   logic                     mc_reg;
   logic                     bc_reg;
   logic                     dhit_reg;
   logic [2:0]               dports_reg;
   logic                     shit_reg;
   logic [2:0]               sports_reg;
   logic                     sovr_reg;
   logic [`SFP_ENT_W-1:0]    lk_data;
   logic                     ent_match;
   logic [23:0]              tick_cnt_reg;
   logic                     tick;
   logic [15:0]              ing_bkt_reg [0:2];
   logic [15:0]              egr_bkt_reg [0:2];
   logic [15:0]              extra_bytes;
   logic [15:0]              pkt_size;
   logic [2:0]               src_bit;
   logic [2:0]               dest;
   logic [2:0]               ports_next;
   logic                     mirror;
   logic                     counted;
   logic                     ing_limited;
   logic                     ing_over;
   logic                     ing_take;

   // Rate code: 0 none, 1..15 in 64Kbps steps, above that 1Mbps steps
   function automatic logic rate_unlim(input logic [`SFP_RATE_W-1:0] code, input logic is_10m);
      rate_unlim = (code == '0) || (is_10m && (code > `SFP_10M_CODE));
   endfunction

   // Bytes credited per tick; tick length makes both step sizes whole
   function automatic logic [15:0] rate_refill(input logic [`SFP_RATE_W-1:0] code);
      if (code <= `SFP_KSTEP_MAX) begin
         rate_refill = 16'({9'h000, code} * `SFP_KSTEP_BYTES);
      end else begin
         rate_refill = 16'({9'h000, code - `SFP_KSTEP_MAX} * `SFP_MSTEP_BYTES);
      end
   endfunction

   // Bucket refill: saturates at capacity, drained by the consumed size
   function automatic logic [15:0] bkt_next(input logic [15:0] bkt, input logic [15:0] take,
                                            input logic [15:0] fill, input logic do_fill);
      logic [15:0] left;
      left = bkt - take;
      if (do_fill) begin
         bkt_next = ((`SFP_BKT_CAP - left) < fill) ? `SFP_BKT_CAP : left + fill;
      end else begin
         bkt_next = left;
      end
   endfunction

   sfp_static_mem u_mem (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (tbl_wr),
      .wr_addr (tbl_addr),
      .wr_data (tbl_wdata),
      .a_addr  (idx_reg),
      .a_data  (lk_data),
      .b_addr  (tbl_addr),
      .b_data  (tbl_rdata)
   );

   // Processor read answer follows the registered memory read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tbl_rvalid <= 1'b0;
      end else begin
         tbl_rvalid <= tbl_rd;
      end
   end

   // Loopback controls for the two PHY ports
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phy_far_loop  <= 1'b0;
         phy_near_loop <= 2'h0;
      end else begin
         phy_far_loop  <= cfg_far_loop;
         phy_near_loop <= cfg_near_loop;
      end
   end

   // Static entry test on the destination only; source never uses this table
   // valid and group match
   assign ent_match = lk_data[`SFP_VALID] &&
                      (lk_data[`SFP_MAC_HI:0] == da_reg) &&
                      (!lk_data[`SFP_USE_FID] || (lk_data[`SFP_FID_HI:`SFP_FID_LO] == fid_reg));

   // Lookup sequencer: two cycles per entry, first valid match wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= sfp_st_idle;
         idx_reg   <= '0;
         pkt_ready <= 1'b0;
      end else begin
         case (state_reg)
            sfp_st_idle: begin
               pkt_ready <= 1'b1;
               idx_reg   <= '0;
               if (pkt_valid && pkt_ready) begin
                  pkt_ready <= 1'b0;
                  state_reg <= sfp_st_read;
               end
            end
            sfp_st_read: begin
               state_reg <= sfp_st_check;
            end
            sfp_st_check: begin
               if (ent_match || (idx_reg == `SFP_TBL_AW'(`SFP_TBL_DEPTH - 1))) begin
                  state_reg <= sfp_st_decide;
               end else begin
                  idx_reg   <= idx_reg + 1'b1;
                  state_reg <= sfp_st_read;
               end
            end
            sfp_st_decide: begin
               state_reg <= sfp_st_idle;
            end
            default: begin
               state_reg <= sfp_st_idle;
            end
         endcase
      end
   end

   // Packet descriptor capture on accept
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         src_reg    <= 2'h0;
         da_reg     <= '0;
         fid_reg    <= 4'h0;
         len_reg    <= 16'h0000;
         err_reg    <= 1'b0;
         mc_reg     <= 1'b0;
         bc_reg     <= 1'b0;
         dhit_reg   <= 1'b0;
         dports_reg <= 3'h0;
      end else if (state_reg == sfp_st_idle && pkt_valid && pkt_ready) begin
         src_reg    <= pkt_src;
         da_reg     <= pkt_da;
         fid_reg    <= pkt_filter_group_id;
         len_reg    <= {5'h00, pkt_len};
         err_reg    <= pkt_err;
         mc_reg     <= pkt_mcast;
         bc_reg     <= pkt_bcast;
         dhit_reg   <= dyn_hit;
         dports_reg <= dyn_ports;
      end
   end

   // Static hit record, cleared at each new packet
   always_ff @(posedge clk) begin
      if (sys_rst || state_reg == sfp_st_idle) begin
         shit_reg   <= 1'b0;
         sports_reg <= 3'h0;
         sovr_reg   <= 1'b0;
      end else if (state_reg == sfp_st_check && ent_match) begin
         shit_reg   <= 1'b1;
         sports_reg <= lk_data[`SFP_FWD_HI:`SFP_FWD_LO];
         sovr_reg   <= lk_data[`SFP_OVERRIDE];
      end
   end

   // Byte count DA..FCS plus optional gap and preamble
   // size accounting
   assign extra_bytes = (cfg_add_ifg ? `SFP_IFG_BYTES : 16'h0000) +
                        (cfg_add_pre ? `SFP_PRE_BYTES : 16'h0000);
   assign pkt_size    = len_reg + extra_bytes;
   assign src_bit     = 3'(3'h1 << src_reg);

   // Forwarding decision for the captured packet
   always_comb begin
      dest        = 3'h0;
      mirror      = 1'b0;
      counted     = 1'b0;
      ing_limited = 1'b0;
      ing_over    = 1'b0;
      if (shit_reg) begin
         dest = (sports_reg == `SFP_FWD_BCAST) ? ~src_bit : (sports_reg & ~src_bit);
      end else if (dhit_reg) begin
         dest = dports_reg & ~src_bit;
      end else if (mc_reg || bc_reg) begin
         dest = ~src_bit;
      end else begin
         dest = cfg_unk_uc_fwd ? ~src_bit : 3'h0;
      end
      if (!(shit_reg && sovr_reg)) begin
         if (!cfg_rx_en[src_reg]) begin
            dest = 3'h0;
         end
         dest = dest & cfg_tx_en;
      end
      case (cfg_mir_mode)
         sfp_mir_rx:   mirror = cfg_rx_sniff[src_reg];
         sfp_mir_tx:   mirror = |(dest & cfg_tx_sniff);
         sfp_mir_both: mirror = cfg_rx_sniff[src_reg] && |(dest & cfg_tx_sniff);
         default:      mirror = 1'b0;
      endcase
      // Bad frames never reach real destinations
      if (err_reg) begin
         dest = 3'h0;
         mirror = cfg_sniff_bad && cfg_rx_sniff[src_reg] &&
                  (cfg_mir_mode == sfp_mir_rx || cfg_mir_mode == sfp_mir_both);
      end
      case (cfg_ing_type)
         sfp_ing_all:   counted = 1'b1;
         sfp_ing_mc:    counted = mc_reg;
         sfp_ing_bc:    counted = bc_reg;
         sfp_ing_flood: counted = !mc_reg && !bc_reg && !shit_reg && !dhit_reg;
         default:       counted = 1'b0;
      endcase
      ing_limited = !rate_unlim(cfg_ing_rate[src_reg*`SFP_RATE_W +: `SFP_RATE_W], link_10m[src_reg]);
      ing_over = counted && ing_limited && (ing_bkt_reg[src_reg] < pkt_size);
      if (ing_over) begin
         dest   = 3'h0;
         mirror = 1'b0;
      end
      ports_next = dest | (mirror ? (3'(3'h1 << cfg_sniff_port) & ~src_bit) : 3'h0);
   end

   assign ing_take = (state_reg == sfp_st_decide) && counted && ing_limited && !ing_over;

   // Decision result, one-cycle strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fwd_valid <= 1'b0;
         fwd_ports <= 3'h0;
         fwd_drop  <= 1'b0;
      end else begin
         fwd_valid <= (state_reg == sfp_st_decide);
         if (state_reg == sfp_st_decide) begin
            fwd_ports <= ports_next;
            fwd_drop  <= (ports_next == 3'h0);
         end
      end
   end

   // Common refill tick; 1 ms keeps both step sizes integral
   always_ff @(posedge clk) begin
      if (sys_rst || tick) begin
         tick_cnt_reg <= 24'h000000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 24'h000001;
      end
   end
   assign tick = (tick_cnt_reg == 24'(TICK_CYCLES - 1));

   // Per-port receive and transmit buckets
   // One shaped queue per port
   for (genvar p = 0; p < 3; p++) begin : g_port
      logic [`SFP_RATE_W-1:0] ing_code;
      logic [`SFP_RATE_W-1:0] egr_code;
      logic                   egr_unlim;
      logic [15:0]            egr_size;
      logic                   egr_ok;
      assign ing_code  = cfg_ing_rate[p*`SFP_RATE_W +: `SFP_RATE_W];
      assign egr_code  = cfg_egr_rate[p*`SFP_RATE_W +: `SFP_RATE_W];
      assign egr_unlim = rate_unlim(egr_code, link_10m[p]);
      assign egr_size  = {5'h00, egr_len[p*11 +: 11]} + extra_bytes;
      assign egr_ok    = egr_req[p] && !egr_grant[p] && (egr_unlim || egr_bkt_reg[p] >= egr_size);

      always_ff @(posedge clk) begin
         if (sys_rst || rate_unlim(ing_code, link_10m[p])) begin
            ing_bkt_reg[p] <= `SFP_BKT_CAP;
         end else begin
            ing_bkt_reg[p] <= bkt_next(ing_bkt_reg[p],
                                       (ing_take && src_reg == 2'(p)) ? pkt_size : 16'h0000,
                                       rate_refill(ing_code), tick);
         end
      end

      always_ff @(posedge clk) begin
         if (sys_rst || egr_unlim) begin
            egr_bkt_reg[p] <= `SFP_BKT_CAP;
         end else begin
            egr_bkt_reg[p] <= bkt_next(egr_bkt_reg[p], egr_ok ? egr_size : 16'h0000,
                                       rate_refill(egr_code), tick);
         end
      end

      // Grant pulse releases one frame to the transmitter
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            egr_grant[p] <= 1'b0;
         end else begin
            egr_grant[p] <= egr_ok;
         end
      end
   end
endmodule

/* testbench/sfp_fwd_chk.sv */
`timescale 1ns/1ps
module sfp_fwd_chk (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        tbl_wr,
   input wire logic        tbl_rd,
   input wire logic [2:0]  tbl_addr,
   input wire logic [57:0] tbl_wdata,
   input wire logic [57:0] tbl_rdata,
   input wire logic        tbl_rvalid,
   input wire logic        cfg_far_loop,
   input wire logic [1:0]  cfg_near_loop,
   input wire logic        pkt_valid,
   input wire logic        pkt_ready,
   input wire logic [1:0]  pkt_src,
   input wire logic        fwd_valid,
   input wire logic [2:0]  fwd_ports,
   input wire logic        fwd_drop,
   input wire logic [2:0]  egr_req,
   input wire logic [2:0]  egr_grant,
   input wire logic        phy_far_loop,
   input wire logic [1:0]  phy_near_loop
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [1:0] src_q;
   // Ingress port of the packet in flight
   always_ff @(posedge clk) begin
      if (pkt_valid && pkt_ready) begin
         src_q <= pkt_src;
      end
   end
   rd_answer_a: assert property (tbl_rd |=> tbl_rvalid) else $error("read answer missing");
   wr_visible_a: assert property (tbl_wr ##1 (tbl_rd && !tbl_wr && tbl_addr == $past(tbl_addr))
      |=> tbl_rdata == $past(tbl_wdata, 2)) else $error("written entry not read back");
   fwd_window_a: assert property (pkt_valid && pkt_ready |=> !fwd_valid [*3] ##[1:16] fwd_valid)
      else $error("decision latency out of range");
   ready_back_a: assert property (fwd_valid |-> !pkt_ready ##1 pkt_ready) else $error("ready not restored");
   drop_flag_a: assert property (fwd_valid |-> fwd_drop == (fwd_ports == 3'h0)) else $error("drop flag wrong");
   no_ingress_a: assert property (fwd_valid |-> !fwd_ports[src_q]) else $error("sent back to ingress");
   grant_cause_a: assert property ((egr_grant & ~($past(egr_req) & ~$past(egr_grant))) == 3'h0)
      else $error("grant without request");
   grant_pulse_a: assert property ((egr_grant & $past(egr_grant)) == 3'h0) else $error("grant too long");
   far_copy_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
      phy_far_loop == $past(cfg_far_loop)) else $error("far loop flag wrong");
   near_copy_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
      phy_near_loop == $past(cfg_near_loop)) else $error("near loop flag wrong");
   cover property (fwd_valid && fwd_ports != 3'h0);
   cover property (fwd_valid && fwd_drop);
   cover property (egr_grant[0]);
endmodule
bind sfp_forwarding_policy sfp_fwd_chk u_sfp_fwd_chk (.*);

/* testbench/sfp_port_model.sv */
`timescale 1ns/1ps
module sfp_port_model (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [47:0] pkt_da,
   input  wire logic [2:0]  want,
   input  wire logic [2:0]  egr_grant,
   output logic             dyn_hit,
   output logic [2:0]       dyn_ports,
   output logic [2:0]       egr_req,
   output logic [32:0]      egr_len
);
   // learned table
   // Tagged addresses hit, ports taken from low bits
   assign dyn_hit = pkt_da[47:40] == 8'hD0;
   assign dyn_ports = pkt_da[2:0];
   // Fixed frame length keeps shaper counts easy to predict
   assign egr_len = {3{11'h5DC}};
   // egress queue
   // Held until granted, dropped right after so no second grant
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         egr_req <= 3'h0;
      end else begin
         egr_req <= (egr_req & ~egr_grant) | (want & ~egr_req & ~egr_grant);
      end
   end
endmodule

/* testbench/test_sfp_forwarding_policy.sv */
`timescale 1ns/1ps
module test_sfp_forwarding_policy
   import sfp_pkg::*;
;
   logic        clk, sys_rst, tbl_wr, tbl_rd, tbl_rvalid, cfg_sniff_bad, cfg_unk_uc_fwd, cfg_add_ifg;
   logic        cfg_add_pre, cfg_far_loop, pkt_valid, pkt_ready, pkt_err, pkt_mcast, pkt_bcast;
   logic        dyn_hit, fwd_valid, fwd_drop, phy_far_loop;
   logic [1:0]  cfg_sniff_port, cfg_near_loop, pkt_src, phy_near_loop;
   logic [2:0]  tbl_addr, cfg_rx_sniff, cfg_tx_sniff, cfg_tx_en, cfg_rx_en, link_10m;
   logic [2:0]  dyn_ports, fwd_ports, egr_req, egr_grant, want;
   logic [3:0]  pkt_filter_group_id;
   logic [10:0] pkt_len;
   logic [20:0] cfg_ing_rate, cfg_egr_rate;
   logic [32:0] egr_len;
   logic [47:0] pkt_da;
   logic [57:0] tbl_wdata, tbl_rdata;
   logic [57:0] tbl_m [8];
   sfp_mir_e    cfg_mir_mode;
   sfp_ing_e    cfg_ing_type;
   int          errors, compares, bkt, gc [3];
   sfp_forwarding_policy #(.TICK_CYCLES(200)) u_sfp_forwarding_policy (.*);
   sfp_port_model u_sfp_port_model (.*);
   // Free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic complete_run;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Inputs always move 2 ns after the edge
   task automatic tick;
      @(posedge clk);
      #2;
   endtask
   task automatic tmo(input int n);
      if (n >= 60) begin
         errors++;
         $display("mismatch wait expected done seen timeout");
         complete_run;
      end
   endtask
   task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_fwd(input logic [3:0] e);
      chk_val("fwd", {60'h0, e}, {60'h0, fwd_drop, fwd_ports});
   endtask
   task automatic rst_dut;
      sys_rst = 1'b1;
      repeat (12) tick;
      sys_rst = 1'b0;
      tbl_m = '{default: '0};
      tick;
   endtask
   task automatic rd(input int a);
      {tbl_addr, tbl_rd} = {3'(a), 1'b1};
      tick;
      tbl_rd = 1'b0;
      chk_val("tbl", {5'h0, 1'b1, tbl_m[a]}, {5'h0, tbl_rvalid, tbl_rdata});
      tick;
   endtask
   task automatic wr(input int a, input logic [57:0] d);
      {tbl_addr, tbl_wdata, tbl_wr} = {3'(a), d, 1'b1};
      tick;
      tbl_wr = 1'b0;
      tbl_m[a] = d;
   endtask
   // Reference forwarding decision, first matching static slot wins
   function automatic logic [3:0] exp_fwd(input int s, input logic [47:0] da, input logic [3:0] fg,
                                          input logic e, input logic m, input logic b);
      logic [2:0] d, ing, mon;
      logic       hit, ov, sn;
      {d, hit, ov} = '0;
      ing = 3'h1 << s;
      mon = 3'h1 << cfg_sniff_port;
      for (int k = 7; k >= 0; k--) begin
         if (tbl_m[k][51] && tbl_m[k][47:0] == da && (!tbl_m[k][53] || tbl_m[k][57:54] == fg)) begin
            {hit, ov, d} = {1'b1, tbl_m[k][52], tbl_m[k][50:48]};
         end
      end
      if (!hit) begin
         d = (da[47:40] == 8'hD0) ? da[2:0] : ((m || b || cfg_unk_uc_fwd) ? 3'h7 : 3'h0);
      end
      d = d & ~ing;
      if (!ov) begin
         d = cfg_rx_en[s] ? (d & cfg_tx_en) : 3'h0;
      end
      sn = cfg_mir_mode != sfp_mir_off && (!cfg_mir_mode[0] || cfg_rx_sniff[s]);
      sn = sn && (!cfg_mir_mode[1] || |(d & cfg_tx_sniff));
      if (e) begin
         d = (cfg_sniff_bad && cfg_mir_mode[0] && cfg_rx_sniff[s]) ? mon : 3'h0;
      end else if (sn) begin
         d = d | mon;
      end
      d = d & ~ing;
      return {d == 3'h0, d};
   endfunction
   task automatic send(input int s, input logic [47:0] da, input logic [3:0] fg, input logic [10:0] ln,
                       input logic e, input logic m, input logic b);
      int n;
      for (n = 0; n < 60 && pkt_ready !== 1'b1; n++) tick;
      tmo(n);
      {pkt_valid, pkt_src, pkt_da, pkt_filter_group_id, pkt_len, pkt_err, pkt_mcast, pkt_bcast} =
         {1'b1, 2'(s), da, fg, ln, e, m, b};
      tick;
      pkt_valid = 1'b0;
      for (n = 0; n < 60 && fwd_valid !== 1'b1; n++) tick;
      tmo(n);
   endtask
   // Random mirror setup and traffic against the static table
   task automatic run_mix(input int md);
      int          s;
      logic [47:0] da;
      logic [3:0]  fg;
      logic        e, m, b;
      cfg_mir_mode = sfp_mir_e'(md);
      {cfg_rx_sniff, cfg_tx_sniff, cfg_sniff_bad, cfg_unk_uc_fwd, cfg_tx_en, cfg_rx_en} = 14'($urandom);
      cfg_sniff_port = 2'($urandom_range(2));
      for (int i = 0; i < 60; i++) begin
         s = $urandom_range(2);
         da = {($urandom % 2) ? 8'hD0 : 8'h5A, 37'h0, 3'($urandom)};
         fg = 4'($urandom_range(1));
         {e, m, b} = {$urandom % 8 == 0, $urandom % 4 == 0, $urandom % 4 == 0};
         send(s, da, fg, 11'h040, e, m, b);
         chk_fwd(exp_fwd(s, da, fg, e, m, b));
      end
   endtask
   initial begin
      {errors, compares} = '0;
      {tbl_wr, tbl_rd, tbl_addr, tbl_wdata, cfg_sniff_bad, cfg_unk_uc_fwd, cfg_add_ifg, cfg_add_pre} = '0;
      {cfg_far_loop, cfg_near_loop, pkt_valid, pkt_src, pkt_da, pkt_filter_group_id, pkt_len} = '0;
      {pkt_err, pkt_mcast, pkt_bcast, cfg_rx_sniff, cfg_tx_sniff, cfg_sniff_port, link_10m, want} = '0;
      {cfg_ing_rate, cfg_egr_rate, cfg_tx_en, cfg_rx_en} = {42'h0, 6'h3F};
      cfg_mir_mode = sfp_mir_off;
      cfg_ing_type = sfp_ing_all;
      void'($urandom(95739));
      rst_dut;
      // Egress shaping from full buckets, before the first refill tick
      cfg_egr_rate = {7'h19, 7'h30, 7'h01};
      link_10m = 3'b110;
      gc = '{default: 0};
      want = 3'h7;
      for (int i = 0; i < 150; i++) begin
         tick;
         for (int p = 0; p < 3; p++) gc[p] += (egr_grant[p] === 1'b1);
      end
      want = 3'h0;
      chk_val("grants0", 64'd5, 64'(gc[0]));
      chk_val("grants2", 64'd5, 64'(gc[2]));
      chk_val("grants1", 64'd1, 64'(gc[1] >= 40));
      repeat (4) tick;
      link_10m = 3'h0;
      for (int i = 0; i < 8; i++) begin
         {cfg_far_loop, cfg_near_loop} = 3'(i);
         repeat (2) tick;
         chk_val("loop", 64'(i), {61'h0, phy_far_loop, phy_near_loop});
      end
      for (int a = 0; a < 8; a++) rd(a);
      for (int a = 0; a < 8; a++) begin
         wr(a, {4'($urandom_range(1)), 6'($urandom), ($urandom % 2) ? 8'hD0 : 8'h5A, 37'h0, 3'($urandom)});
         rd(a);
      end
      run_mix(1);
      run_mix(2);
      run_mix(3);
      run_mix(0);
      for (int a = 0; a < 8; a++) rd(a);
      // Ingress policing on port 0, with and without the extra bytes
      for (int a = 0; a < 2; a++) begin
         rst_dut;
         {cfg_mir_mode, cfg_unk_uc_fwd, cfg_ing_rate} = {sfp_mir_off, 1'b1, 21'h1};
         {cfg_add_ifg, cfg_add_pre} = {2{a[0]}};
         bkt = 8192;
         for (int t = 0; t < 4; t++) begin
            cfg_ing_type = sfp_ing_e'(t);
            for (int k = 0; k < 4; k++) begin
               logic cnt, ok;
               cnt = t == 0 || t == k;
               ok = !cnt || bkt >= 1630 + a * 20;
               bkt -= (cnt && ok) ? 1630 + a * 20 : 0;
               send(0, k == 0 ? 48'hD000_0000_0006 : 48'h5A00_0000_0001, 4'h0, 11'd1630, 1'b0, k == 1, k == 2);
               chk_fwd(ok ? exp_fwd(0, pkt_da, 4'h0, 1'b0, k == 1, k == 2) : 4'h8);
            end
         end
      end
      complete_run;
   end
endmodule
